// ==== rtl/sec_top.sv ====
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`include "sec_defines.svh"
module sec_top
    import sec_pkg::*;
#(
    parameter int NPORT = 3
) (
    input  wire logic                  pclk,           // APB clock, 40 MHz.
    input  wire logic                  presetn,        // Reset, active low.
    input  wire logic                  psel,           // APB select.
    input  wire logic                  penable,        // APB enable.
    input  wire logic                  pwrite,         // APB direction.
    input  wire logic [31:0]           paddr,          // APB byte address.
    input  wire logic [31:0]           pwdata,         // APB write data.
    output logic      [31:0]           prdata,         // APB read data.
    output logic                       pready,         // APB ready.
    output logic                       pslverr,        // APB error.
    input  wire logic                  sleep_exec,     // Core executes sleep.
    input  wire logic                  irq_req,        // Any interrupt flag.
    input  wire logic                  wdt_timeout,    // Watchdog expiry pulse.
    input  wire logic                  wake_pin,       // Async wake pin.
    input  wire logic [`SEC_N_OSC-1:0] osc_req,        // Peripheral osc requests.
    input  wire logic                  adc_busy,       // Conversion running.
    input  wire logic [NPORT-1:0]      port_periph_on, // Peripheral active per port.
    output logic                       cpu_clk_en,     // CPU clock gate.
    output logic                       sys_clk_en,     // System clock gate.
    output logic                       prog_mem_en,    // Program memory enable.
    output logic                       periph_clk_en,  // Peripheral clock gate.
    output logic [`SEC_N_OSC-1:0]      osc_run,        // hf, lf, secondary.
    output logic                       adc_power_en,   // ADC analog power.
    output logic                       adc_abort,      // Abort conversion pulse.
    output logic                       wdt_clear,      // Clear watchdog pulse.
    output logic                       wdt_run_en,     // Watchdog counting.
    output logic                       wdt_reset_req,  // Watchdog reset pulse.
    output logic                       resume,         // Resume execution pulse.
    output logic [NPORT-1:0]           port_hold,      // Freeze port drive.
    output logic                       irq             // Interrupt, active high.
);
    // ****************************************
    // Declarations
    // ****************************************
    sec_mode_t                 mode;
    sec_mode_t                 next_mode;
    logic                      idle_select;
    logic                      wdt_in_sleep;
    logic [`SEC_N_OSC-1:0]     osc_force;
    logic                      power_down_flag_n;
    logic                      time_out_flag_n;
    logic [`SEC_N_EV-1:0]      istat;
    logic [`SEC_N_EV-1:0]      imask;
    logic                      adc_on_bit;
    logic                      adc_rc_clock;
    logic                      adc_off;
    logic                      wake_sync;
    logic                      enter_sleep;
    logic                      enter_idle;
    logic                      wake;
    logic                      wdt_wake;
    logic                      wr;
    logic [`SEC_N_EV-1:0]      ev;
    logic [`SEC_ADDR_W-1:0]    off;

    // Address decode shared by writes and the error answer; reads decode with a case on the offset.
    function automatic logic hit(input logic [`SEC_ADDR_W-1:0] a,
                                 input logic [`SEC_ADDR_W-1:0] o);
        hit = (a == o);
    endfunction

    // True for any of the six register offsets; anything else answers with an error.
    function automatic logic mapped(input logic [`SEC_ADDR_W-1:0] a);
        mapped = hit(a, `SEC_OFF_CTRL) | hit(a, `SEC_OFF_OSC_ENABLE_REGISTER) |
                 hit(a, `SEC_OFF_STATUS) | hit(a, `SEC_OFF_ISTAT) |
                 hit(a, `SEC_OFF_IMASK) | hit(a, `SEC_OFF_ADC);
    endfunction

    // ****************************************
    // Wake pin and oscillators
    // ****************************************
    sec_sync u_wake_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (wake_pin),
        .q       (wake_sync)
    );

    sec_osc_keep #(
        .N (`SEC_N_OSC)
    ) u_osc (
        .pclk     (pclk),
        .presetn  (presetn),
        .sleeping (mode == SEC_SLEEP),
        .req      (osc_req),
        .force_on (osc_force),
        .run      (osc_run)
    );

    // ****************************************
    // APB slave
    // ****************************************
    // Every access completes in its first access cycle, so no wait states.
    assign pready  = 1'b1;
    assign off     = paddr[`SEC_ADDR_W-1:0];
    assign wr      = psel & penable & pwrite & mapped(off);
    assign pslverr = psel & penable & ~mapped(off);

    // Read data is registered off the setup phase so it is stable in access.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `SEC_ZERO32;
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= `SEC_ZERO32;
            case (off)
                `SEC_OFF_CTRL: begin
                    prdata[`SEC_CTRL_IDLE]   <= idle_select;
                    prdata[`SEC_CTRL_WDTSLP] <= wdt_in_sleep;
                end
                `SEC_OFF_OSC_ENABLE_REGISTER: begin
                    prdata[`SEC_N_OSC-1:0] <= osc_force;
                end
                `SEC_OFF_STATUS: begin
                    prdata[`SEC_ST_PD] <= power_down_flag_n;
                    prdata[`SEC_ST_TO] <= time_out_flag_n;
                    prdata[`SEC_ST_MODE_HI:`SEC_ST_MODE_LO] <= mode;
                end
                `SEC_OFF_ISTAT: begin
                    prdata[`SEC_N_EV-1:0] <= istat;
                end
                `SEC_OFF_IMASK: begin
                    prdata[`SEC_N_EV-1:0] <= imask;
                end
                `SEC_OFF_ADC: begin
                    prdata[`SEC_ADC_ON] <= adc_on_bit;
                    prdata[`SEC_ADC_RC] <= adc_rc_clock;
                end
                default: begin
                    prdata <= `SEC_ZERO32;
                end
            endcase
        end
    end

    // Control register; idle select is never touched by hardware.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_select  <= 1'b0;
            wdt_in_sleep <= 1'b0;
        end else if (wr && hit(off, `SEC_OFF_CTRL)) begin
            idle_select  <= pwdata[`SEC_CTRL_IDLE];
            wdt_in_sleep <= pwdata[`SEC_CTRL_WDTSLP];
        end
    end

    // Oscillator force-on bits.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_force <= '0;
        end else if (wr && hit(off, `SEC_OFF_OSC_ENABLE_REGISTER)) begin
            osc_force <= pwdata[`SEC_N_OSC-1:0];
        end
    end

    // ADC control: on bit and clock source select.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_on_bit   <= 1'b0;
            adc_rc_clock <= 1'b0;
        end else if (wr && hit(off, `SEC_OFF_ADC)) begin
            adc_on_bit   <= pwdata[`SEC_ADC_ON];
            adc_rc_clock <= pwdata[`SEC_ADC_RC];
        end
    end

    // Interrupt mask.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            imask <= '0;
        end else if (wr && hit(off, `SEC_OFF_IMASK)) begin
            imask <= pwdata[`SEC_N_EV-1:0];
        end
    end

    // ****************************************
    // Mode sequencer
    // ****************************************
    assign enter_sleep = (mode == SEC_RUN) & sleep_exec & ~idle_select;
    assign enter_idle  = (mode == SEC_RUN) & sleep_exec & idle_select;
    // Idle ignores the global interrupt enable; any raised flag wakes.
    assign wdt_wake    = (mode != SEC_RUN) & wdt_timeout;
    assign wake        = (mode == SEC_IDLE) & (irq_req | wdt_timeout) |
                         (mode == SEC_SLEEP) & (irq_req | wake_sync |
                                                wdt_timeout);

    // Next mode; a sleep instruction outside run is ignored.
    always_comb begin
        next_mode = mode;
        case (mode)
            SEC_RUN: begin
                if (enter_sleep) begin
                    next_mode = SEC_SLEEP;
                end else if (enter_idle) begin
                    next_mode = SEC_IDLE;
                end
            end
            SEC_SLEEP: begin
                if (wake) begin
                    next_mode = SEC_RUN;
                end
            end
            SEC_IDLE: begin
                if (wake) begin
                    next_mode = SEC_RUN;
                end
            end
            default: begin
                next_mode = SEC_RUN;
            end
        endcase
    end

    // Mode register; every gate below is derived from its next value.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= SEC_RUN;
        end else begin
            mode <= next_mode;
        end
    end

    // ****************************************
    // Clock gates
    // ****************************************
    // Gates are registered so the clock tree sees glitch-free enables.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_clk_en    <= 1'b1;
            sys_clk_en    <= 1'b1;
            prog_mem_en   <= 1'b1;
            periph_clk_en <= 1'b1;
        end else begin
            cpu_clk_en    <= (next_mode == SEC_RUN);
            sys_clk_en    <= (next_mode != SEC_SLEEP);
            prog_mem_en   <= (next_mode == SEC_RUN);
            periph_clk_en <= (next_mode != SEC_SLEEP);
        end
    end

    // Resume pulse: core continues after the sleep instruction.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resume <= 1'b0;
        end else begin
            resume <= wake;
        end
    end

    // ****************************************
    // Watchdog and status flags
    // ****************************************
    // Entry clears the count; only the watchdog sees sleep, other resets don't.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_clear     <= 1'b0;
            wdt_run_en    <= 1'b1;
            wdt_reset_req <= 1'b0;
        end else begin
            wdt_clear     <= enter_sleep | enter_idle;
            wdt_run_en    <= (next_mode != SEC_SLEEP) | wdt_in_sleep;
            wdt_reset_req <= wdt_timeout & (mode == SEC_RUN);
        end
    end

    // Flags come up set; a run-mode watchdog reset clears the time-out flag.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_down_flag_n <= 1'b1;
            time_out_flag_n   <= 1'b1;
        end else if (enter_sleep) begin
            power_down_flag_n <= 1'b0;
            time_out_flag_n   <= 1'b1;
        end else if (wdt_timeout && mode == SEC_RUN) begin
            time_out_flag_n   <= 1'b0;
        end
    end

    // ****************************************
    // ADC handling
    // ****************************************
    // Only a non-RC clock dies in sleep, so only then is the ADC shut off.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_off   <= 1'b0;
            adc_abort <= 1'b0;
        end else begin
            adc_abort <= enter_sleep & ~adc_rc_clock & adc_busy;
            if (enter_sleep && !adc_rc_clock) begin
                adc_off <= 1'b1;
            end else if (mode != SEC_SLEEP) begin
                adc_off <= 1'b0;
            end
        end
    end

    // The on bit stays set; only the analog power is cut while asleep.
    assign adc_power_en = adc_on_bit & ~adc_off;

    // ****************************************
    // Port hold
    // ****************************************
    // A port with a live peripheral must follow it, so it cannot be frozen.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_hold <= '0;
        end else begin
            port_hold <= {NPORT{next_mode == SEC_SLEEP}} & ~port_periph_on;
        end
    end

    // ****************************************
    // Interrupt status
    // ****************************************
    // Events in status bit order.
    assign ev = {wdt_wake, wake, enter_idle, enter_sleep};

    // New events win over a write-one-to-clear in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat <= '0;
        end else if (wr && hit(off, `SEC_OFF_ISTAT)) begin
            istat <= (istat & ~pwdata[`SEC_N_EV-1:0]) | ev;
        end else begin
            istat <= istat | ev;
        end
    end

    // Level interrupt while any unmasked status bit is set.
    assign irq = |(istat & imask);
endmodule // sec_top

// ==== rtl/sec_defines.svh ====
// How it works
// - Sleep instruction with idle select clear enters full sleep.
// - Sleep instruction with idle select set enters idle instead.
// - Entry clears watchdog count; it keeps running if enabled in sleep.
// - Full-sleep entry clears the active-low power-down flag; idle entry leaves it.
// - Full-sleep entry sets the active-low time-out flag; idle entry leaves it.
// - Sleep stops both the CPU clock and the system clock.
// - Each oscillator runs in sleep if requested or forced on.
// - ADC on its own RC clock is untouched by sleep.
// - Other ADC clock: entry aborts conversion, powers ADC off, on bit stays.
// - A port holds its state in sleep only with no active peripheral.
// - Idle halts CPU and program memory, peripheral clocks keep running.
// - Any interrupt ends idle regardless of global enable; idle select kept.
// - Watchdog timeout in idle wakes the device instead of resetting it.
`ifndef SEC_DEFINES_SVH
`define SEC_DEFINES_SVH
// ****************************************
// Register map
// ****************************************
`define SEC_ADDR_W      8
`define SEC_OFF_CTRL    8'h00
`define SEC_OFF_OSC_ENABLE_REGISTER   8'h04
`define SEC_OFF_STATUS  8'h08
`define SEC_OFF_ISTAT   8'h0C
`define SEC_OFF_IMASK   8'h10
`define SEC_OFF_ADC     8'h14
// ****************************************
// Field positions
// ****************************************
`define SEC_CTRL_IDLE   0
`define SEC_CTRL_WDTSLP 1
`define SEC_ST_PD       0
`define SEC_ST_TO       1
`define SEC_ST_MODE_LO  2
`define SEC_ST_MODE_HI  3
`define SEC_ADC_ON      0
`define SEC_ADC_RC      1
`define SEC_EV_SLEEP    0
`define SEC_EV_IDLE     1
`define SEC_EV_WAKE     2
`define SEC_EV_WDT      3
`define SEC_N_EV        4
`define SEC_N_OSC       3
`define SEC_ZERO32      32'h00000000
`endif

// ==== rtl/sec_pkg.sv ====
package sec_pkg;
    // Power mode of the device.
    typedef enum logic [1:0] {
        SEC_RUN   = 2'b00,
        SEC_SLEEP = 2'b01,
        SEC_IDLE  = 2'b10
    } sec_mode_t;
endpackage

// ==== rtl/sec_sync.sv ====
`timescale 1ns/10ps
module sec_sync (
    input  wire logic pclk,    // Clock.
    input  wire logic presetn, // Reset, active low.
    input  wire logic d,       // Asynchronous level.
    output logic      q        // Synchronised level.
);
    logic stage1;

    // Two flops; only the second one is visible outside.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1 <= 1'b0;
            q      <= 1'b0;
        end else begin
            stage1 <= d;
            q      <= stage1;
        end
    end
endmodule // sec_sync

// ==== rtl/sec_osc_keep.sv ====
`timescale 1ns/10ps
module sec_osc_keep #(
    parameter int N = 3
) (
    input  wire logic         pclk,     // Clock.
    input  wire logic         presetn,  // Reset, active low.
    input  wire logic         sleeping, // Device is in full sleep.
    input  wire logic [N-1:0] req,      // Peripheral clock requests.
    input  wire logic [N-1:0] force_on, // Software force-on bits.
    output logic      [N-1:0] run       // Oscillator run enables.
);
    // Outside sleep every oscillator may run; in sleep only wanted ones.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run <= {N{1'b1}};
        end else begin
            run <= {N{~sleeping}} | req | force_on;
        end
    end
endmodule // sec_osc_keep

// ==== dv/sec_top_assertions.sv ====
`timescale 1ns/10ps
`include "sec_defines.svh"
module sec_top_assertions #(
    parameter int NPORT = 3
) (
    input wire logic                  pclk,           // Clock.
    input wire logic                  presetn,        // Reset.
    input wire logic                  sleep_exec,     // Sleep op.
    input wire logic                  irq_req,        // Irq flag.
    input wire logic                  wdt_timeout,    // Wdt expiry.
    input wire logic [`SEC_N_OSC-1:0] osc_req,        // Osc asks.
    input wire logic [NPORT-1:0]      port_periph_on, // Port users.
    input wire logic                  cpu_clk_en,     // Cpu gate.
    input wire logic                  sys_clk_en,     // Sys gate.
    input wire logic                  prog_mem_en,    // Pm on.
    input wire logic                  periph_clk_en,  // Periph gate.
    input wire logic [`SEC_N_OSC-1:0] osc_run,        // Osc on.
    input wire logic                  wdt_clear,      // Wdt clear.
    input wire logic                  wdt_run_en,     // Wdt runs.
    input wire logic                  wdt_reset_req,  // Wdt reset.
    input wire logic                  resume,         // Resume.
    input wire logic [NPORT-1:0]      port_hold       // Hold.
);
    // ********
    // Checks
    // ********
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Any entry from run halts the core and restarts the watchdog count.
    property p_entry;
        sleep_exec && cpu_clk_en |=> !cpu_clk_en && !prog_mem_en && wdt_clear;
    endproperty
    a_entry: assert property (p_entry) else $error("entry left core running");
    property p_sleep_clk;
        !sys_clk_en |-> !cpu_clk_en && !periph_clk_en;
    endproperty
    a_sleep_clk: assert property (p_sleep_clk) else $error("clock alive in sleep");
    // Idle keeps peripherals clocked while program memory is off.
    property p_idle;
        !cpu_clk_en && sys_clk_en |-> periph_clk_en && !prog_mem_en;
    endproperty
    a_idle: assert property (p_idle) else $error("idle gating wrong");
    // Requests lag one cycle, so compare against the previous request.
    property p_osc_req;
        1'b1 |=> (osc_run & $past(osc_req)) == $past(osc_req);
    endproperty
    a_osc_req: assert property (p_osc_req) else $error("requested osc stopped");
    property p_osc_run;
        $past(sys_clk_en) |-> osc_run == 3'h7;
    endproperty
    a_osc_run: assert property (p_osc_run) else $error("osc off while awake");
    property p_wdt_run;
        sys_clk_en |-> wdt_run_en;
    endproperty
    a_wdt_run: assert property (p_wdt_run) else $error("watchdog stopped");
    property p_hold;
        !sys_clk_en && !$past(sys_clk_en) |-> port_hold == ~$past(port_periph_on);
    endproperty
    a_hold: assert property (p_hold) else $error("port hold wrong");
    property p_wake;
        $rose(cpu_clk_en) |-> resume && sys_clk_en && prog_mem_en;
    endproperty
    a_wake: assert property (p_wake) else $error("wake without resume");
    property p_idle_irq;
        !cpu_clk_en && sys_clk_en && irq_req |=> cpu_clk_en && resume;
    endproperty
    a_idle_irq: assert property (p_idle_irq) else $error("irq left idle");
    property p_idle_wdt;
        !cpu_clk_en && wdt_timeout |=> cpu_clk_en && !wdt_reset_req;
    endproperty
    a_idle_wdt: assert property (p_idle_wdt) else $error("wdt reset in low power");
endmodule // sec_top_assertions

bind sec_top sec_top_assertions #(.NPORT(NPORT)) sec_top_assertions_inst (
    .pclk(pclk), .presetn(presetn), .sleep_exec(sleep_exec), .irq_req(irq_req),
    .wdt_timeout(wdt_timeout), .osc_req(osc_req), .port_periph_on(port_periph_on),
    .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en), .prog_mem_en(prog_mem_en),
    .periph_clk_en(periph_clk_en), .osc_run(osc_run), .wdt_clear(wdt_clear),
    .wdt_run_en(wdt_run_en), .wdt_reset_req(wdt_reset_req), .resume(resume),
    .port_hold(port_hold)
);

// ==== dv/sec_core_model.sv ====
`timescale 1ns/10ps
module sec_core_model #(
    parameter int NPORT = 3
) (
    input  wire logic        pclk,           // Clock.
    output logic             sleep_exec,     // Sleep op.
    output logic             irq_req,        // Irq flag.
    output logic             wdt_timeout,    // Wdt expiry.
    output logic             wake_pin,       // Wake pin.
    output logic [2:0]       osc_req,        // Osc asks.
    output logic             adc_busy,       // Converting.
    output logic [NPORT-1:0] port_periph_on  // Port users.
);
    // ********
    // Core side
    // ********
    // Quiet core at time zero, so no wake or entry is seen during reset.
    initial begin
        {sleep_exec, irq_req, wdt_timeout, wake_pin, adc_busy} = 5'h0;
        osc_req = 3'h0;
        port_periph_on = '0;
    end
    // Peripheral levels all move together just after an edge.
    task automatic set_lines(input logic [2:0] o, input logic b,
                             input logic [NPORT-1:0] p, input logic i, input logic w);
        @(posedge pclk);
        osc_req <= o;
        adc_busy <= b;
        port_periph_on <= p;
        irq_req <= i;
        wake_pin <= w;
    endtask
    // Sleep instruction or watchdog expiry, one cycle wide.
    task automatic pulse(input logic wdt);
        @(posedge pclk);
        sleep_exec <= !wdt;
        wdt_timeout <= wdt;
        @(posedge pclk);
        sleep_exec <= 1'b0;
        wdt_timeout <= 1'b0;
    endtask
endmodule // sec_core_model

// ==== dv/tb_top.sv ====
`timescale 1ns/10ps
`include "sec_defines.svh"
module tb_top
    import sec_pkg::*;
;
    localparam int NPORT = 3;
    logic             pclk = 1'b0;
    logic             presetn = 1'b0;
    logic             psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0]      paddr = '0, pwdata = '0, prdata;
    logic             pready, pslverr, sleep_exec, irq_req, wdt_timeout, wake_pin, adc_busy;
    logic [2:0]       osc_req, osc_run;
    logic             cpu_clk_en, sys_clk_en, prog_mem_en, periph_clk_en, adc_power_en;
    logic             adc_abort, wdt_clear, wdt_run_en, wdt_reset_req, resume, irq;
    logic [NPORT-1:0] port_periph_on, port_hold;
    logic [31:0]      rd_q[$];
    int               fails = 0, comparisons = 0, cycles = 0;
    // ********
    // Harness
    // ********
    sec_top #(.NPORT(NPORT)) sec_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleep_exec(sleep_exec), .irq_req(irq_req), .wdt_timeout(wdt_timeout),
        .wake_pin(wake_pin), .osc_req(osc_req), .adc_busy(adc_busy),
        .port_periph_on(port_periph_on), .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en),
        .prog_mem_en(prog_mem_en), .periph_clk_en(periph_clk_en), .osc_run(osc_run),
        .adc_power_en(adc_power_en), .adc_abort(adc_abort), .wdt_clear(wdt_clear),
        .wdt_run_en(wdt_run_en), .wdt_reset_req(wdt_reset_req), .resume(resume),
        .port_hold(port_hold), .irq(irq));
    sec_core_model #(.NPORT(NPORT)) sec_core_model_inst (
        .pclk(pclk), .sleep_exec(sleep_exec), .irq_req(irq_req), .wdt_timeout(wdt_timeout),
        .wake_pin(wake_pin), .osc_req(osc_req), .adc_busy(adc_busy),
        .port_periph_on(port_periph_on));
    always #12.5 pclk = ~pclk;
    task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Read expectations are queued at setup; the monitor pops one per completed read.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        if (!wr) rd_q.push_back(d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        check("pslverr", pslverr, a > `SEC_OFF_ADC);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    always @(posedge pclk) begin
        if ((psel & penable & pready & ~pwrite) === 1'b1) begin
            check("prdata", prdata, rd_q.pop_front());
        end
    end
    // The pin path adds two sync cycles, so the wait allows a few more.
    task automatic wait_resume();
        int k;
        k = 0;
        #1;
        while (resume !== 1'b1 && k < 8) begin
            @(posedge pclk);
            #1;
            k++;
        end
        check("resume", resume, 1);
    endtask
    // A hang ends the run as a failure.
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            test_done();
        end
    end
    // ********
    // Scenarios
    // ********
    initial begin
        logic [2:0]       r_osc, r_force;
        logic [NPORT-1:0] r_port;
        void'($urandom(40417));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, `SEC_OFF_ADC, 32'h1);
        for (int i = 0; i < 3; i++) begin
            r_osc = 3'($urandom);
            r_force = 3'($urandom);
            r_port = NPORT'($urandom);
            apb(1'b1, `SEC_OFF_CTRL, {30'h0, i == 1, 1'b0});
            apb(1'b1, `SEC_OFF_OSC_ENABLE_REGISTER, {29'h0, r_force});
            apb(1'b1, `SEC_OFF_IMASK, {29'h0, i == 2, 2'b00});
            sec_core_model_inst.set_lines(r_osc, 1'b1, r_port, 1'b0, 1'b0);
            sec_core_model_inst.pulse(1'b0);
            #1;
            check("sleep", {cpu_clk_en, sys_clk_en, prog_mem_en, periph_clk_en, wdt_clear,
                  adc_abort, adc_power_en, wdt_run_en},
                  {7'b0000110, i == 1});
            check("port_hold", port_hold, NPORT'(~r_port));
            @(posedge pclk);
            #1;
            check("osc_run", osc_run, r_osc | r_force);
            apb(1'b0, `SEC_OFF_STATUS, {28'h0, SEC_SLEEP, 2'b10});
            apb(1'b0, `SEC_OFF_ADC, 32'h1);
            sec_core_model_inst.set_lines(r_osc, 1'b0, r_port, i != 0, i == 0);
            wait_resume();
            sec_core_model_inst.set_lines(r_osc, 1'b0, r_port, 1'b0, 1'b0);
            #1;
            check("wake", {adc_power_en, irq}, {1'b1, i == 2});
            apb(1'b0, `SEC_OFF_ISTAT, 32'h5);
            apb(1'b1, `SEC_OFF_ISTAT, 32'h5);
            #1;
            check("irq clear", irq, 0);
            apb(1'b0, `SEC_OFF_ISTAT, 32'h0);
        end
        // Idle with the ADC on its own RC clock: conversion must survive.
        apb(1'b1, `SEC_OFF_CTRL, 32'h1);
        apb(1'b1, `SEC_OFF_ADC, 32'h3);
        sec_core_model_inst.set_lines(3'h0, 1'b1, '1, 1'b0, 1'b0);
        sec_core_model_inst.pulse(1'b0);
        #1;
        check("idle", {cpu_clk_en, sys_clk_en, prog_mem_en, periph_clk_en, wdt_clear,
              adc_abort, adc_power_en, wdt_run_en}, 8'b01011011);
        apb(1'b0, `SEC_OFF_STATUS, {28'h0, SEC_IDLE, 2'b10});
        sec_core_model_inst.set_lines(3'h0, 1'b1, '1, 1'b1, 1'b0);
        wait_resume();
        sec_core_model_inst.set_lines(3'h0, 1'b0, '0, 1'b0, 1'b0);
        apb(1'b0, `SEC_OFF_CTRL, 32'h1);
        apb(1'b1, `SEC_OFF_ISTAT, 32'hF);
        apb(1'b1, `SEC_OFF_IMASK, 32'h8);
        sec_core_model_inst.pulse(1'b0);
        sec_core_model_inst.pulse(1'b1);
        wait_resume();
        check("wdt wake irq", irq, 1);
        // In run the same expiry must request a reset and drop the time-out flag.
        apb(1'b1, `SEC_OFF_IMASK, 32'h0);
        sec_core_model_inst.pulse(1'b1);
        #1;
        check("wdt reset", wdt_reset_req, 1);
        apb(1'b0, `SEC_OFF_STATUS, {28'h0, SEC_RUN, 2'b00});
        apb(1'b0, 8'h20, 32'h0);
        test_done();
    end
endmodule // tb_top
